// File: core/chan_ctrl_regs.svh
`ifndef CHAN_CTRL_REGS_SVH
`define CHAN_CTRL_REGS_SVH
// register addresses
`define CFG_FIRST_ADDR 8'h01
`define CFG_LAST_ADDR 8'h04
`define CTRL_ADDR 8'h05
`define MODE_FIRST_ADDR 8'h06
`define MODE_LAST_ADDR 8'h11
// reset values
`define CFG_RESET 8'h0A
`define MODE_RESET 8'h00
`define CTRL_RESET 8'h00
`define UNMAPPED_DATA 8'h00
// control register field positions
`define SRC_LSB 4
`define ON_LSB 0
// store layout and byte framing
`define CFG_WORDS 4
`define MEM_WORDS 16
`define MODE_IDX_BASE 4'h4
`define BYTE_BITS 4'h8
`endif

// File: core/chan_ctrl_pkg.sv
package chan_ctrl_pkg;
  // serial target states, gray along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WR = 4'h7,
    ST_WR_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hC
  } link_state_t;
  typedef logic [7:0] byte_t;
endpackage

// File: core/line_events_if.sv
`timescale 1ns/1ps
// bus line events passed from the sampler to the target logic
interface line_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport snk (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// File: core/line_sampler.sv
`timescale 1ns/1ps
module line_sampler (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  line_events_if.src ev
);
  logic scl_q_r;
  logic sda_q_r;

  // previous line levels, idle bus is high
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= i_scl;
      sda_q_r <= i_sda;
    end
  end

  // edges and start/stop conditions
  assign ev.scl_rise = i_scl & ~scl_q_r;
  assign ev.scl_fall = ~i_scl & scl_q_r;
  assign ev.start = scl_q_r & i_scl & sda_q_r & ~i_sda;
  assign ev.stop = scl_q_r & i_scl & ~sda_q_r & i_sda;
  assign ev.sda = i_sda;
endmodule // line_sampler

// File: core/reg_store.sv
`timescale 1ns/1ps
`include "chan_ctrl_regs.svh"
module reg_store #(
  parameter int WORDS = `MEM_WORDS,
  parameter int CFG_WORDS = `CFG_WORDS
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_we,
  input wire logic [3:0] i_widx,
  input wire logic [7:0] i_wdata,
  input wire logic [3:0] i_ridx,
  output logic [7:0] o_rdata,
  output logic [8*CFG_WORDS-1:0] o_cfg
);
  logic [7:0] mem_r [WORDS];

  // config words first, mode words after; all return to defaults on reset
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      for (int k = 0; k < WORDS; k++)
        mem_r[k] <= (k < CFG_WORDS) ? `CFG_RESET : `MODE_RESET;
      o_rdata <= `MODE_RESET;
    end
    else
    begin
      if (i_we)
        mem_r[i_widx] <= i_wdata;
      o_rdata <= mem_r[i_ridx];
    end
  end

  // per-channel settings toward the switch
  for (genvar g = 0; g < CFG_WORDS; g++)
  begin : g_cfg
    assign o_cfg[8*g +: 8] = mem_r[g];
  end
endmodule // reg_store

// File: core/quad_channel_enable_control.sv
`timescale 1ns/1ps
`include "chan_ctrl_regs.svh"
// Summary of operation
// - after power-up every channel follows its own on-pin, not its register bit.
// - the control register sits at 05h, bits 7..4 pick the source of channels 4..1, reset 0.
// - under register control bits 3..0 switch channels 4..1, 0 off and 1 on.
// - one register write turns a register-controlled channel from off to on.
// - with all channels on register control one write switches them all at once.
// - registers are volatile and reset returns each of them to its default.
// - there are 17 writable registers: four config, one control, twelve mode.
// - every register reads back through the ordinary serial register read.
// - a pin-controlled channel is on whenever its on-pin is high.
// - with no programming each channel uses its default slew, delay and bleed settings.
// - moving a pin-enabled channel to register control with its bit at 0 turns it off.
// - a source select bit of 0 means pin control and 1 means register control.
// - the four config registers sit at 01h to 04h, one per channel.
// - the twelve mode registers sit at 06h to 11h.
module quad_channel_enable_control #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // arbitrary default target address
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic [3:0] i_channel_on_pin,
  output logic [3:0] o_channel_output,
  output logic [31:0] o_chan_cfg
);
  chan_ctrl_pkg::link_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  chan_ctrl_pkg::byte_t shift_r, shift_nxt;
  chan_ctrl_pkg::byte_t ptr_r, ptr_nxt;
  chan_ctrl_pkg::byte_t ctrl_r;
  chan_ctrl_pkg::byte_t wr_addr_r;
  chan_ctrl_pkg::byte_t wr_data_r;
  logic oe_n_r, oe_n_nxt;
  logic rw_r, rw_nxt;
  logic wr_r, wr_nxt;
  logic [3:0] chan_on_r;
  logic sda_low_r;
  logic [7:0] mem_rdata;

  line_events_if ev();

  // store index for config and mode addresses
  function automatic logic [3:0] store_idx(input logic [7:0] a);
    logic [7:0] d;
    d = (a <= `CFG_LAST_ADDR) ? (a - `CFG_FIRST_ADDR) : (a - 8'h02);
    return d[3:0];
  endfunction

  // address falls in the config or mode range
  function automatic logic in_store(input logic [7:0] a);
    logic hit_cfg;
    logic hit_mode;
    hit_cfg = (a >= `CFG_FIRST_ADDR) && (a <= `CFG_LAST_ADDR);
    hit_mode = (a >= `MODE_FIRST_ADDR) && (a <= `MODE_LAST_ADDR);
    return hit_cfg | hit_mode;
  endfunction

  line_sampler u_sampler (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .ev(ev.src)
  );

  // byte framing and read source decode
  wire byte_done = (cnt_r == `BYTE_BITS);
  wire addr_match = (shift_r[7:1] == DEV_ADDR);
  wire ptr_is_ctrl = (ptr_r == `CTRL_ADDR);
  wire ptr_in_store = in_store(ptr_r);
  wire [3:0] rd_idx = store_idx(ptr_r);
  wire [7:0] rd_byte = ptr_is_ctrl ? ctrl_r : ptr_in_store ? mem_rdata : `UNMAPPED_DATA;
  wire [3:0] src_sel = ctrl_r[`SRC_LSB +: 4];
  wire [3:0] on_bits = ctrl_r[`ON_LSB +: 4];

  // write decode, config, control and mode words
  wire ctrl_we = wr_r && (wr_addr_r == `CTRL_ADDR);
  wire mem_we = wr_r && in_store(wr_addr_r);
  wire [3:0] mem_widx = store_idx(wr_addr_r);

  // source select: 0 follows the pin, 1 follows the stored bit
  wire [3:0] chan_on_nxt = (src_sel & on_bits)
    | (~src_sel & i_channel_on_pin);

  // serial target sequencing
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    oe_n_nxt = oe_n_r;
    rw_nxt = rw_r;
    wr_nxt = 1'b0;
    if (ev.stop)
    begin
      state_nxt = chan_ctrl_pkg::ST_IDLE;
      oe_n_nxt = 1'b1;
    end
    else if (ev.start)
    begin
      state_nxt = chan_ctrl_pkg::ST_ADDR;
      cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end
    else
    begin
      unique case (state_r)
        chan_ctrl_pkg::ST_IDLE:
          state_nxt = chan_ctrl_pkg::ST_IDLE;
        chan_ctrl_pkg::ST_ADDR, chan_ctrl_pkg::ST_PTR, chan_ctrl_pkg::ST_WR:
        begin
          if (ev.scl_rise && !byte_done)
          begin
            shift_nxt = {shift_r[6:0], ev.sda};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (ev.scl_fall && byte_done)
          begin
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b0;
            if (state_r == chan_ctrl_pkg::ST_ADDR)
            begin
              if (addr_match)
              begin
                state_nxt = chan_ctrl_pkg::ST_ADDR_ACK;
                rw_nxt = shift_r[0];
              end
              else
              begin
                state_nxt = chan_ctrl_pkg::ST_IDLE;
                oe_n_nxt = 1'b1;
              end
            end
            else if (state_r == chan_ctrl_pkg::ST_PTR)
            begin
              ptr_nxt = shift_r;
              state_nxt = chan_ctrl_pkg::ST_PTR_ACK;
            end
            else
            begin
              wr_nxt = 1'b1;
              ptr_nxt = ptr_r + 8'h01;
              state_nxt = chan_ctrl_pkg::ST_WR_ACK;
            end
          end
        end
        chan_ctrl_pkg::ST_ADDR_ACK, chan_ctrl_pkg::ST_RD_ACK:
        begin
          if (state_r == chan_ctrl_pkg::ST_RD_ACK && ev.scl_rise && ev.sda)
          begin
            state_nxt = chan_ctrl_pkg::ST_IDLE; // controller ends the read
          end
          else if (ev.scl_fall && (rw_r || state_r == chan_ctrl_pkg::ST_RD_ACK))
          begin
            shift_nxt = rd_byte;
            oe_n_nxt = rd_byte[7];
            cnt_nxt = 4'h1;
            ptr_nxt = ptr_r + 8'h01;
            state_nxt = chan_ctrl_pkg::ST_RD;
          end
          else if (ev.scl_fall)
          begin
            oe_n_nxt = 1'b1;
            state_nxt = chan_ctrl_pkg::ST_PTR;
          end
        end
        chan_ctrl_pkg::ST_PTR_ACK, chan_ctrl_pkg::ST_WR_ACK:
        begin
          if (ev.scl_fall)
          begin
            oe_n_nxt = 1'b1;
            state_nxt = chan_ctrl_pkg::ST_WR;
          end
        end
        chan_ctrl_pkg::ST_RD:
        begin
          if (ev.scl_fall && !byte_done)
          begin
            shift_nxt = {shift_r[6:0], 1'b0};
            oe_n_nxt = shift_r[6];
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (ev.scl_fall)
          begin
            oe_n_nxt = 1'b1;
            cnt_nxt = 4'h0;
            state_nxt = chan_ctrl_pkg::ST_RD_ACK;
          end
        end
        default:
          state_nxt = chan_ctrl_pkg::ST_IDLE;
      endcase
    end
  end

  // target state registers
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r <= chan_ctrl_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      oe_n_r <= 1'b1;
      rw_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      oe_n_r <= oe_n_nxt;
      rw_r <= rw_nxt;
    end
  end

  // one-cycle write strobe with its address and data
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_r <= 1'b0;
      wr_addr_r <= 8'h00;
      wr_data_r <= 8'h00;
    end
    else
    begin
      wr_r <= wr_nxt;
      if (wr_nxt)
      begin
        wr_addr_r <= ptr_r;
        wr_data_r <= shift_r;
      end
    end
  end

  // control register, cleared by every bias power cycle
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      ctrl_r <= `CTRL_RESET;
    else if (ctrl_we)
      ctrl_r <= wr_data_r;
  end

  // channel enables and open-drain data level
  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      chan_on_r <= 4'h0;
      sda_low_r <= 1'b0;
    end
    else
    begin
      chan_on_r <= chan_on_nxt;
      sda_low_r <= 1'b0;
    end
  end

  reg_store #(
    .WORDS(`MEM_WORDS),
    .CFG_WORDS(`CFG_WORDS)
  ) u_store (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_we(mem_we),
    .i_widx(mem_widx),
    .i_wdata(wr_data_r),
    .i_ridx(rd_idx),
    .o_rdata(mem_rdata),
    .o_cfg(o_chan_cfg)
  );

  assign o_sda = sda_low_r;
  assign o_sda_oe_n = oe_n_r;
  assign o_channel_output = chan_on_r;

  // checks on the control path
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  a_src_after_reset:
  assert property ($past(i_rst) |-> src_sel == 4'h0
    ##1 o_channel_output == $past(i_channel_on_pin))
    else $error("channels not on pin control after reset");
  a_ctrl_write_lands:
  assert property (ctrl_we |=> ctrl_r == $past(wr_data_r))
    else $error("control write not stored");
  a_reg_bits_drive:
  assert property (1'b1 |=> ((o_channel_output ^ $past(on_bits)) & $past(src_sel)) == 4'h0)
    else $error("register controlled channel disagrees with its bit");
  a_single_write_on:
  assert property (ctrl_we && wr_data_r[4] && wr_data_r[0] |-> ##2 o_channel_output[0])
    else $error("single write did not turn channel on");
  a_all_together:
  assert property (state_r == chan_ctrl_pkg::ST_WR && ev.scl_fall && byte_done && ptr_is_ctrl
    && shift_r[7:4] == 4'hF |-> ##3 o_channel_output == $past(shift_r[3:0], 3))
    else $error("channels did not switch together");
  a_defaults_reset:
  assert property ($past(i_rst) |-> o_chan_cfg == {4{`CFG_RESET}} && ctrl_r == `CTRL_RESET)
    else $error("registers not at defaults after reset");
  a_mode_range:
  assert property (wr_r && wr_addr_r >= `MODE_FIRST_ADDR && wr_addr_r <= `MODE_LAST_ADDR
    |-> mem_we && mem_widx == 4'(wr_addr_r - `MODE_FIRST_ADDR) + `MODE_IDX_BASE)
    else $error("mode write missed its store word");
  a_cfg_first:
  assert property (wr_r && wr_addr_r == `CFG_FIRST_ADDR |=> o_chan_cfg[7:0] == $past(wr_data_r))
    else $error("first config write not stored");
  a_read_byte:
  assert property (state_r == chan_ctrl_pkg::ST_ADDR_ACK && ev.scl_fall && rw_r && !ev.stop
    && !ev.start |=> state_r == chan_ctrl_pkg::ST_RD && shift_r == $past(rd_byte))
    else $error("read byte not loaded");
  a_pin_follow:
  assert property (1'b1
    |=> ((o_channel_output ^ $past(i_channel_on_pin)) & ~$past(src_sel)) == 4'h0)
    else $error("pin controlled channel ignores its pin");
  a_move_to_off:
  assert property (ctrl_we && wr_data_r == 8'hF0 |-> ##2 o_channel_output == 4'h0)
    else $error("channel not off after move to register control");

  c_ctrl_write: cover property (ctrl_we);
  c_read_load: cover property (state_r == chan_ctrl_pkg::ST_RD && byte_done);
  c_all_reg_on: cover property (src_sel == 4'hF && o_channel_output == 4'hF);
  c_read_nack: cover property (state_r == chan_ctrl_pkg::ST_RD_ACK
    ##1 state_r == chan_ctrl_pkg::ST_IDLE);
endmodule // quad_channel_enable_control

// File: verif/i2c_ctrl_model.sv
`timescale 1ns/1ps
// serial bus controller on an open-drain pair with pull-up
module i2c_ctrl_model #(
  parameter int QTR = 3,
  parameter logic [6:0] TGT = 7'h2A
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  logic [7:0] nacks;
  // idle bus: both lines released
  initial
  begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    nacks = 8'h00;
  end
  // quarter bit time, lines change just after an edge
  task automatic step();
    repeat (QTR) @(posedge i_clk);
    #1;
  endtask
  // start or repeated start
  task automatic start();
    o_sda_low = 1'b0;
    step();
    o_scl = 1'b1;
    step();
    o_sda_low = 1'b1;
    step();
    o_scl = 1'b0;
    step();
  endtask
  // stop from a low clock
  task automatic stop();
    o_sda_low = 1'b1;
    step();
    o_scl = 1'b1;
    step();
    o_sda_low = 1'b0;
    step();
  endtask
  // one bit, sampled in the middle of the high phase
  task automatic bit_io(input logic b, output logic s);
    o_sda_low = ~b;
    step();
    o_scl = 1'b1;
    step();
    s = i_sda;
    step();
    o_scl = 1'b0;
    step();
  endtask
  // byte msb first plus ninth bit; a read ends with a nack
  task automatic byte_io(input logic [7:0] d, input logic rd, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'b1, a);
    if (!rd && a !== 1'b0) nacks = nacks + 8'h01;
  endtask
  // pointer then n data bytes in one transfer
  task automatic wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [31:0] d,
                    input int n);
    logic [7:0] q;
    start();
    byte_io({dev, 1'b0}, 1'b0, q);
    byte_io(ptr, 1'b0, q);
    for (int k = 0; k < n; k++) byte_io(d[8*k +: 8], 1'b0, q);
    stop();
  endtask
  // plain register read: pointer, repeated start, one byte
  task automatic rd(input logic [7:0] ptr, output logic [7:0] q);
    logic [7:0] x;
    start();
    byte_io({TGT, 1'b0}, 1'b0, x);
    byte_io(ptr, 1'b0, x);
    start();
    byte_io({TGT, 1'b1}, 1'b0, x);
    byte_io(8'hFF, 1'b1, q);
    stop();
  endtask
endmodule // i2c_ctrl_model

// File: verif/tb.sv
`timescale 1ns/1ps
`include "chan_ctrl_regs.svh"
// self-checking bench for the channel enable control
module tb;
  localparam logic [6:0] TGT = 7'h2A;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [3:0] i_channel_on_pin = 4'h0;
  logic scl;
  logic m_low;
  logic o_sda;
  logic o_sda_oe_n;
  logic [3:0] o_channel_output;
  logic [31:0] o_chan_cfg;
  logic watch = 1'b0;
  logic [7:0] split = 8'h00;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  wire logic sda_line;
  // open-drain wire with pull-up
  assign sda_line = ~m_low & (o_sda_oe_n | o_sda);
  always #2.5 i_clk = ~i_clk;
  quad_channel_enable_control #(.DEV_ADDR(TGT)) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_scl(scl), .i_sda(sda_line), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n),
    .i_channel_on_pin(i_channel_on_pin), .o_channel_output(o_channel_output),
    .o_chan_cfg(o_chan_cfg));
  i2c_ctrl_model #(.TGT(TGT)) ctl (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl),
    .o_sda_low(m_low));
  // verdict and end of run
  task automatic conclude();
    if (fail_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // partial switching watch, sampled away from the launching edge
  always @(negedge i_clk)
  begin
    if (watch && o_channel_output !== 4'h0 && o_channel_output !== 4'hF) split++;
  end
  // hang guard
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fail_count++;
      conclude();
    end
  end
  // compare tasks
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk4(input string what, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // expected channel state and default register value
  function automatic logic [3:0] exp_out(input logic [7:0] c, input logic [3:0] p);
    return (c[7:4] & c[3:0]) | (~c[7:4] & p);
  endfunction
  function automatic logic [7:0] exp_def(input logic [7:0] a);
    return (a >= `CFG_FIRST_ADDR && a <= `CFG_LAST_ADDR) ? `CFG_RESET : 8'h00;
  endfunction
  // drive pins and let the one-clock path settle
  task automatic pins(input logic [3:0] p);
    i_channel_on_pin = p;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic do_reset(input int n);
    i_rst = 1'b1;
    repeat (n) @(posedge i_clk);
    #1;
    i_rst = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  // every address 00h..12h plus config port and pin following
  task automatic check_defaults();
    logic [7:0] q;
    for (int a = 0; a <= 18; a++)
    begin
      ctl.rd(8'(a), q);
      chk8("reset value", exp_def(8'(a)), q);
    end
    for (int k = 0; k < 4; k++) chk8("cfg port", `CFG_RESET, o_chan_cfg[8*k +: 8]);
    chk4("channels after reset", i_channel_on_pin, o_channel_output);
  endtask
  // main sequence
  initial
  begin
    logic [7:0] q;
    logic [7:0] c;
    logic [7:0] a;
    logic [7:0] d;
    void'($urandom(85));
    i_channel_on_pin = 4'($urandom);
    do_reset(5);
    check_defaults();
    ctl.wr(TGT, `CTRL_ADDR, 32'h0F, 1);
    pins(4'h0);
    chk4("pin control", 4'h0, o_channel_output);
    ctl.rd(`CTRL_ADDR, q);
    chk8("stored on bits", 8'h0F, q);
    pins(4'hF);
    chk4("pins high", 4'hF, o_channel_output);
    ctl.wr(TGT, `CTRL_ADDR, 32'hF0, 1);
    chk4("moved to register", 4'h0, o_channel_output);
    watch = 1'b1;
    ctl.wr(TGT, `CTRL_ADDR, 32'hFF, 1);
    chk4("all on", 4'hF, o_channel_output);
    ctl.wr(TGT, `CTRL_ADDR, 32'hF0, 1);
    chk4("all off", 4'h0, o_channel_output);
    watch = 1'b0;
    chk8("split switching", 8'h00, split);
    ctl.wr(TGT ^ 7'h01, `CTRL_ADDR, 32'h5A, 1);
    chk8("refused bytes", 8'h03, ctl.nacks);
    ctl.rd(`CTRL_ADDR, q);
    chk8("control kept", 8'hF0, q);
    ctl.wr(TGT, `CFG_FIRST_ADDR, 32'h44332211, 4);
    for (int k = 0; k < 4; k++)
      chk8("cfg burst", 8'(8'h11 * (k + 1)), o_chan_cfg[8*k +: 8]);
    ctl.wr(TGT, 8'h10, 32'h00A5C3, 3);
    ctl.rd(8'h10, q);
    chk8("mode 10h", 8'hC3, q);
    ctl.rd(`MODE_LAST_ADDR, q);
    chk8("mode 11h", 8'hA5, q);
    ctl.rd(8'h12, q);
    chk8("past last", 8'h00, q);
    // random control, pins and register traffic
    for (int i = 0; i < 12; i++)
    begin
      c = 8'($urandom);
      a = 8'h01 + 8'($urandom % 17);
      d = 8'($urandom);
      ctl.wr(TGT, `CTRL_ADDR, {24'h0, c}, 1);
      ctl.wr(TGT, a, {24'h0, d}, 1);
      if (a == `CTRL_ADDR) c = d;
      pins(4'($urandom));
      chk4("channel state", exp_out(c, i_channel_on_pin), o_channel_output);
      ctl.rd(a, q);
      chk8("read back", d, q);
    end
    i_channel_on_pin = 4'($urandom);
    do_reset(3);
    check_defaults();
    conclude();
  end
endmodule // tb
